// [bench/req_pins.sv]
// model of the external request and power-down pins
`timescale 1ns/1ps
module req_pins (
  input  wire logic       sys_clk,
  output logic      [6:0] pin_n
);
  // lines idle high, as with their pull-ups; bit 6 is the power-down pin
  initial pin_n = 7'h7F;

  // hold a line at a level until told otherwise
  task automatic hold(input int i, input logic v);
    @(posedge sys_clk);
    pin_n[i] <= v;
  endtask

  // edge-triggered requests and pin-driven power-down
  // one falling edge, released after one cycle so that no level request lingers
  task automatic strike(input int i);
    hold(i, 1'b0);
    hold(i, 1'b1);
  endtask
endmodule // req_pins

// [bench/testbench.sv]
// self-checking bench of the interrupt and low-power controller
`timescale 1ns/1ps
module testbench;
  import irq_lp_pkg::*;
  logic              sys_clk   = 1'b0;
  logic              sys_rst   = 1'b1;
  logic [ADDR_W-1:0] reg_addr  = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [6:0]        pin_n;
  logic [5:0]        preq      = '0;
  logic [4:0]        instr     = '0;
  logic [2:0]        div       = '0;
  logic              vector_valid;
  logic [VEC_W-1:0]  vector_addr;
  logic [3:0]        stack_level;
  logic              core_stall;
  logic              core_clk_en;
  logic              derived_clk_en;
  logic              power_down_ack;
  logic              context_clear;
  int                fails       = 0;
  int                checks_done = 0;
  int                n;

  always #10 sys_clk = ~sys_clk;

  req_pins i_src (.sys_clk(sys_clk), .pin_n(pin_n));

  irq_lp_ctrl i_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_request_line_0_n(pin_n[0]), .ext_request_line_1_n(pin_n[1]),
    .ext_request_line_2_n(pin_n[2]), .edge_request_pin_n(pin_n[3]),
    .level_request_pin_0_n(pin_n[4]), .level_request_pin_1_n(pin_n[5]),
    .power_down_request_pin_n(pin_n[6]),
    .sa_tx_req(preq[0]), .sa_rx_req(preq[1]), .dma_req(preq[2]),
    .sb_tx_req(preq[3]), .sb_rx_req(preq[4]), .timer_req(preq[5]),
    .global_interrupt_enable_instr(instr[0]), .global_interrupt_disable_instr(instr[1]),
    .idle_instr(instr[2]), .idle_div_code(div), .rti_instr(instr[3]),
    .pd_commit(instr[4]), .vector_valid(vector_valid), .vector_addr(vector_addr),
    .stack_level(stack_level), .core_stall(core_stall), .core_clk_en(core_clk_en),
    .derived_clk_en(derived_clk_en), .power_down_ack(power_down_ack),
    .context_clear(context_clear)
  );

  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
                    input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 cmp(reg_rdata & m, exp);
  endtask

  task automatic go(input int k);
    @(posedge sys_clk);
    instr[k] <= 1'b1;
    @(posedge sys_clk);
    instr[k] <= 1'b0;
  endtask

  task automatic fire(input int k);
    @(posedge sys_clk);
    preq[k] <= 1'b1;
    @(posedge sys_clk);
    preq[k] <= 1'b0;
  endtask

  task automatic wait_vec(input logic [VEC_W-1:0] exp);
    int c;
    c = 0;
    do begin
      @(posedge sys_clk);
      #1 c++;
    end while (vector_valid !== 1'b1 && c < 40);
    cmp({vector_valid, vector_addr}, {1'b1, exp});
  endtask

  task automatic no_vec(input int cyc);
    repeat (cyc) begin
      @(posedge sys_clk);
      #1 cmp(vector_valid, 1'b0);
    end
  endtask

  task automatic give_verdict;
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // all scenarios, the oscillator-off wake included, take about 6,000 cycles
  initial begin
    #400_000;
    fails++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wait_vec(VEC_RESET);
    rd(OFS_STATUS, 32'h100000, 32'h100000);
    rd(OFS_MASK, 32'h7FF, 32'h0);
    rd(OFS_FORCE_CLEAR, '1, 32'h0);
    rd(3'h7, '1, 32'h0);
    wr(OFS_MASK, 32'h7FE);
    // two forced requests, the higher first
    wr(OFS_FORCE_CLEAR, 32'h410);
    wait_vec(14'h0010);
    go(3);
    wait_vec(14'h0028);
    go(3);
    rd(OFS_PENDING, 32'h7FF, 32'h0);
    wr(OFS_MASK, 32'h77E);
    wr(OFS_FORCE_CLEAR, 32'h80);
    wr(OFS_FORCE_CLEAR, 32'h800000);
    wr(OFS_MASK, 32'h7FE);
    no_vec(6);
    // nested: the higher request preempts and deepens the stack
    wr(OFS_CTRL, 32'h8);
    fire(5);
    wait_vec(14'h0028);
    fire(0);
    wait_vec(14'h0010);
    cmp(stack_level, 4'h2);
    go(3);
    go(3);
    // sequential: the second waits for the return
    wr(OFS_CTRL, 32'h0);
    fire(5);
    wait_vec(14'h0028);
    fire(0);
    no_vec(5);
    go(3);
    wait_vec(14'h0010);
    go(3);
    // masked request is held until unmasked
    wr(OFS_MASK, 32'h3FE);
    fire(5);
    no_vec(5);
    wr(OFS_MASK, 32'h7FE);
    wait_vec(14'h0028);
    go(3);
    go(1);
    rd(OFS_STATUS, 32'h100000, 32'h0);
    fire(5);
    no_vec(5);
    go(0);
    wait_vec(14'h0028);
    go(3);
    // pins: both level pins, edge pin and configurable lines 0 and 2
    i_src.hold(4, 1'b0);
    wait_vec(14'h000C);
    i_src.hold(4, 1'b1);
    go(3);
    i_src.hold(5, 1'b0);
    wait_vec(14'h0008);
    i_src.hold(5, 1'b1);
    go(3);
    i_src.strike(3);
    wait_vec(14'h0018);
    go(3);
    i_src.hold(2, 1'b0);
    wait_vec(14'h0004);
    i_src.hold(2, 1'b1);
    go(3);
    i_src.hold(0, 1'b0);
    wait_vec(14'h0024);
    i_src.hold(0, 1'b1);
    go(3);
    wr(OFS_CTRL, 32'h4);
    i_src.strike(2);
    wait_vec(14'h0004);
    go(3);
    no_vec(5);
    wr(OFS_CTRL, 32'h0);
    // power-down ignores the mask, then wake with the clock running
    wr(OFS_MASK, 32'h0);
    i_src.strike(6);
    wait_vec(VEC_PD);
    go(4);
    @(posedge sys_clk);
    #1 cmp({power_down_ack, core_stall, core_clk_en}, 3'b110);
    i_src.strike(6);
    n = 0;
    while (power_down_ack === 1'b1 && n < 400) begin
      @(posedge sys_clk);
      #1 n++;
    end
    cmp(n >= 290 && n <= 305, 1'b1);
    cmp(stack_level, 4'h1);
    go(3);
    i_src.strike(6);
    wait_vec(VEC_PD);
    go(4);
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 cmp(power_down_ack, 1'b0);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    wait_vec(VEC_RESET);
    wr(OFS_MASK, 32'h7FE);
    // software force, then an oscillator-off wake into a clean context
    wr(OFS_CTRL, 32'h30);
    wr(OFS_PD_FORCE, 32'h1);
    wait_vec(VEC_PD);
    go(4);
    i_src.strike(6);
    n = 0;
    while (context_clear !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    cmp(n, 32'hFFF);
    wait_vec(VEC_RESET);
    rd(OFS_STATUS, 32'h1F07FF, 32'h100000);
    wr(OFS_CTRL, 32'h0);
    // plain idle halts until a serviced request
    div <= 3'h0;
    go(2);
    #1 cmp(core_stall, 1'b1);
    fire(5);
    wait_vec(14'h0028);
    go(3);
    #1 cmp(core_stall, 1'b0);
    // slow idle: the enables pulse once per divisor over a whole window
    for (int k = 1; k <= 4; k++) begin
      @(posedge sys_clk);
      div <= 3'(k);
      go(2);
      repeat (3) @(posedge sys_clk);
      n = 0;
      repeat (256) begin
        @(posedge sys_clk);
        #1 n += int'(core_clk_en === 1'b1) + 1000 * int'(derived_clk_en !== core_clk_en);
      end
      cmp(n, 256 >> (3 + k));
      fire(5);
      wait_vec(14'h0028);
      go(3);
      #1 cmp(core_clk_en, 1'b1);
    end
    give_verdict();
  end
endmodule // testbench

// [hdl/irq_lp_ctrl.sv]
// interrupt priority, masking, vectoring and low-power control
//
// How it works
// - fixed vectors; reset 0x0000, power-down 0x002C, then ascending to timer 0x0028
// - pending requests are ANDed with the mask, highest unmasked one is taken
// - power-down request ignores its mask position
// - a mask write blocks every interrupt for the next cycle
// - control bit picks nested or sequential handling
// - each of ext lines 0..2 is edge or level sensitive per control bit
// - edge pin latches a request which software may force or clear
// - level pins request for as long as they are held low
// - write-only force/clear register; reads give zero
// - entry pushes and return pops a twelve-level status stack
// - global enable gates all servicing, power-down included, apart from the mask
// - global servicing is enabled after reset
// - wake with clock running resumes after 300 input clocks
// - wake with oscillator stopped waits 4096 input clocks
// - power-down starts from the pin or the software force bit
// - power-down request is a nonmaskable edge interrupt; handler commits later
// - on wake, context bit selects resume or restart from reset vector
// - reset ends power-down
// - acknowledge output is high while powered down
// - idle halts until an unmasked interrupt, then services it and resumes
// - slow idle divides the core clock by 16, 32, 64 or 128
// - derived clock enable follows the same divided rate
`timescale 1ns/1ps
module irq_lp_ctrl
  import irq_lp_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              ext_request_line_0_n,
  input  wire logic              ext_request_line_1_n,
  input  wire logic              ext_request_line_2_n,
  input  wire logic              edge_request_pin_n,
  input  wire logic              level_request_pin_0_n,
  input  wire logic              level_request_pin_1_n,
  input  wire logic              power_down_request_pin_n,
  input  wire logic              sa_tx_req,
  input  wire logic              sa_rx_req,
  input  wire logic              dma_req,
  input  wire logic              sb_tx_req,
  input  wire logic              sb_rx_req,
  input  wire logic              timer_req,
  input  wire logic              global_interrupt_enable_instr,
  input  wire logic              global_interrupt_disable_instr,
  input  wire logic              idle_instr,
  input  wire logic [2:0]        idle_div_code,
  input  wire logic              rti_instr,
  input  wire logic              pd_commit,
  output logic                   vector_valid,
  output logic      [VEC_W-1:0]  vector_addr,
  output logic      [3:0]        stack_level,
  output logic                   core_stall,
  output logic                   core_clk_en,
  output logic                   derived_clk_en,
  output logic                   power_down_ack,
  output logic                   context_clear
);

  typedef struct packed {
    pwr_e              state;
    logic [2:0]        div;
    logic [6:0]        cnt;
    logic [11:0]       wcnt;
    logic [NSRC-1:0]   mask;
    logic [NSRC-1:0]   pend;
    logic [NSRC-1:0]   isr;
    logic [CTRL_W-1:0] ctrl;
    logic              gie;
    logic              block;
    logic              boot;
    logic [3:0]        depth;
    logic [4:0]        pin_prev;
    logic              vec_valid;
    logic [VEC_W-1:0]  vec_addr;
    logic              clk_en;
    logic              ack;
    logic              stall;
    logic              ctx_clr;
    logic [DATA_W-1:0] rdata;
  } ctl_s;

  localparam ctl_s CTL_RST = '{state: PWR_RUN, mask: MASK_RST, ctrl: CTRL_RST,
                               gie: GIE_RST, boot: 1'b1, pin_prev: 5'h1F,
                               clk_en: 1'b1, default: '0};

  ctl_s s_q;
  ctl_s s_d;

  // {found, index} of the highest-priority set bit
  function automatic logic [IDX_W:0] pick(input logic [NSRC-1:0] v);
    pick = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        pick = {1'b1, IDX_W'(i)};
      end
    end
  endfunction

  function automatic logic [VEC_W-1:0] vector_of(input logic [IDX_W-1:0] idx);
    vector_of = (idx == SRC_PD) ? VEC_PD : VEC_W'({idx, 2'b00});
  endfunction

  logic [4:0]      pin_now;
  logic [4:0]      fall;
  logic [NSRC-1:0] lvl;
  logic [NSRC-1:0] eset;
  logic [NSRC-1:0] fc_set;
  logic [NSRC-1:0] fc_clr;
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] allow;
  logic [NSRC-1:0] elig;
  logic [NSRC-1:0] svc_oh;
  logic [NSRC-1:0] rti_oh;
  logic [IDX_W:0]  pk_top;
  logic [IDX_W:0]  pk_svc;
  logic            run_ok;
  logic            svc;
  logic            pop;
  logic [6:0]      lim;
  logic [CTRL_W-1:0] ctl;

  always_comb begin
    s_d = s_q;
    ctl = s_q.ctrl;
    pin_now = {power_down_request_pin_n, edge_request_pin_n, ext_request_line_2_n,
               ext_request_line_1_n, ext_request_line_0_n};
    fall = s_q.pin_prev & ~pin_now;
    s_d.pin_prev = pin_now;
    s_d.vec_valid = 1'b0;
    s_d.ctx_clr = 1'b0;
    s_d.block = 1'b0;
    s_d.rdata = '0;
    fc_set = '0;
    fc_clr = '0;
    eset = '0;
    lvl = '0;
    lim = 7'h0F;
    eset[SRC_PD] = fall[4] && s_q.state != PWR_PD && s_q.state != PWR_WAKE;
    eset[SRC_EXT2] = ctl[CTRL_EDGE_LSB + 2] && fall[2];
    eset[SRC_SB_TX] = sb_tx_req || (ctl[CTRL_EDGE_LSB + 1] && fall[1]);
    eset[SRC_SB_RX] = sb_rx_req || (ctl[CTRL_EDGE_LSB] && fall[0]);
    lvl[SRC_EXT2] = !ctl[CTRL_EDGE_LSB + 2] && !ext_request_line_2_n;
    lvl[SRC_SB_TX] = !ctl[CTRL_EDGE_LSB + 1] && !ext_request_line_1_n;
    lvl[SRC_SB_RX] = !ctl[CTRL_EDGE_LSB] && !ext_request_line_0_n;
    eset[SRC_EDGE] = fall[3];
    lvl[SRC_LVL0] = !level_request_pin_0_n;
    lvl[SRC_LVL1] = !level_request_pin_1_n;
    eset[SRC_SA_TX] = sa_tx_req;
    eset[SRC_SA_RX] = sa_rx_req;
    eset[SRC_DMA] = dma_req;
    eset[SRC_TIMER] = timer_req;

    if (reg_wr) begin
      case (reg_addr)
        OFS_MASK: begin
          s_d.mask = reg_wdata[NSRC-1:0];
          s_d.block = 1'b1;
        end
        OFS_CTRL: s_d.ctrl = reg_wdata[CTRL_W-1:0];
        OFS_FORCE_CLEAR: begin
          fc_set = reg_wdata[NSRC-1:0];
          fc_clr = reg_wdata[FC_CLEAR_LSB +: NSRC];
        end
        OFS_PD_FORCE: eset[SRC_PD] = eset[SRC_PD] || reg_wdata[PD_FORCE_BIT];
        default: ;
      endcase
    end

    if (global_interrupt_enable_instr) begin
      s_d.gie = 1'b1;
    end else if (global_interrupt_disable_instr) begin
      s_d.gie = 1'b0;
    end

    req = s_q.pend | lvl;
    pk_top = pick(s_q.isr);
    // nested only preempts lower levels, sequential waits for none active
    for (int i = 0; i < NSRC; i++) begin
      allow[i] = (s_q.isr == '0) ||
                 (ctl[CTRL_NEST_BIT] && IDX_W'(i) < pk_top[IDX_W-1:0]);
    end
    run_ok = s_q.gie && !s_q.block && !s_q.boot && s_q.depth < STACK_LEVELS &&
             (s_q.state == PWR_RUN || s_q.state == PWR_IDLE || s_q.state == PWR_SLOW);
    // mask gate, power-down bit always passes
    elig = req & {s_q.mask[NSRC-1:1], 1'b1} & allow & {NSRC{run_ok}};
    pk_svc = pick(elig);
    svc = pk_svc[IDX_W];
    svc_oh = '0;
    if (svc) begin
      svc_oh[pk_svc[IDX_W-1:0]] = 1'b1;
    end
    pop = rti_instr && pk_top[IDX_W];
    rti_oh = '0;
    if (pop) begin
      rti_oh[pk_top[IDX_W-1:0]] = 1'b1;
    end

    // service clears latch; a new edge wins over any clear
    s_d.pend = (s_q.pend & ~fc_clr & ~svc_oh) | eset | fc_set;
    s_d.isr = (s_q.isr & ~rti_oh) | svc_oh;
    if (svc && !pop) begin
      s_d.depth = s_q.depth + 4'h1;
    end else if (!svc && pop) begin
      s_d.depth = s_q.depth - 4'h1;
    end

    if (s_q.boot) begin
      s_d.boot = 1'b0;
      s_d.vec_valid = 1'b1;
      s_d.vec_addr = VEC_RESET;
    end else if (svc) begin
      s_d.vec_valid = 1'b1;
      s_d.vec_addr = vector_of(pk_svc[IDX_W-1:0]);
    end

    case (s_q.div)
      3'h1: lim = 7'h0F;
      3'h2: lim = 7'h1F;
      3'h3: lim = 7'h3F;
      3'h4: lim = 7'h7F;
      default: lim = 7'h0F;
    endcase
    case (s_q.state)
      PWR_RUN: begin
        if (pd_commit && s_q.isr[SRC_PD]) begin
          s_d.state = PWR_PD;
        end else if (idle_instr) begin
          s_d.div = idle_div_code;
          s_d.cnt = '0;
          s_d.state = (idle_div_code == IDLE_PLAIN) ? PWR_IDLE : PWR_SLOW;
        end
      end
      PWR_IDLE: begin
        if (svc) begin
          s_d.state = PWR_RUN;
        end
      end
      PWR_SLOW: begin
        s_d.cnt = (s_q.cnt == lim) ? 7'h00 : s_q.cnt + 7'h01;
        if (svc) begin
          s_d.state = PWR_RUN;
        end
      end
      PWR_PD: begin
        if (fall[4]) begin
          s_d.state = PWR_WAKE;
          s_d.wcnt = ctl[CTRL_XTAL_OFF_BIT] ? WAKE_XTAL_LOAD : WAKE_RUN_LOAD;
        end
      end
      PWR_WAKE: begin
        if (s_q.wcnt == '0) begin
          s_d.state = PWR_RUN;
          if (ctl[CTRL_RESTART_BIT]) begin
            s_d.ctx_clr = 1'b1;
            s_d.boot = 1'b1;
            s_d.isr = '0;
            s_d.pend = '0;
            s_d.depth = '0;
          end
        end else begin
          s_d.wcnt = s_q.wcnt - 12'h001;
        end
      end
      default: s_d.state = PWR_RUN;
    endcase
    // one enable paces core and derived clocks
    case (s_d.state)
      PWR_SLOW: s_d.clk_en = (s_q.state == PWR_SLOW) && (s_q.cnt == lim);
      PWR_PD, PWR_WAKE: s_d.clk_en = 1'b0;
      default: s_d.clk_en = 1'b1;
    endcase
    s_d.ack = (s_d.state == PWR_PD) || (s_d.state == PWR_WAKE);
    s_d.stall = s_d.ack || (s_d.state == PWR_IDLE);

    if (reg_rd) begin
      case (reg_addr)
        OFS_MASK: s_d.rdata = DATA_W'(s_q.mask);
        OFS_CTRL: s_d.rdata = DATA_W'(s_q.ctrl);
        OFS_STATUS: begin
          s_d.rdata[NSRC-1:0] = s_q.isr;
          s_d.rdata[STAT_DEPTH_LSB +: 4] = s_q.depth;
          s_d.rdata[STAT_GIE_BIT] = s_q.gie;
          s_d.rdata[STAT_ACK_BIT] = s_q.ack;
          s_d.rdata[STAT_STATE_LSB +: 3] = s_q.state;
        end
        OFS_PENDING: s_d.rdata = DATA_W'(req);
        // write-only and unmapped words read zero
        default: s_d.rdata = '0;
      endcase
    end
  end
  // reset ends power-down and enables servicing
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= CTL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata      = s_q.rdata;
  assign vector_valid   = s_q.vec_valid;
  assign vector_addr    = s_q.vec_addr;
  assign stack_level    = s_q.depth;
  assign core_stall     = s_q.stall;
  assign core_clk_en    = s_q.clk_en;
  assign derived_clk_en = s_q.clk_en;
  assign power_down_ack = s_q.ack;
  assign context_clear  = s_q.ctx_clr;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_take(logic [IDX_W-1:0] idx);
    svc && pk_svc[IDX_W-1:0] == idx;
  endsequence
  sequence s_pd_exit;
    s_q.state == PWR_PD && fall[4] && !s_q.ctrl[CTRL_XTAL_OFF_BIT];
  endsequence
  property p_vec_pd;
    s_take(SRC_PD) |=> vector_valid && vector_addr == 14'h002C;
  endproperty
  a_vec_pd: assert property (p_vec_pd) else $error("bad power-down vector");
  property p_vec_timer;
    s_take(SRC_TIMER) |=> vector_valid && vector_addr == 14'h0028;
  endproperty
  a_vec_timer: assert property (p_vec_timer) else $error("bad timer vector");
  property p_masked;
    svc && pk_svc[IDX_W-1:0] != SRC_PD |-> s_q.mask[pk_svc[IDX_W-1:0]];
  endproperty
  a_masked: assert property (p_masked) else $error("masked source serviced");
  property p_pd_nomask;
    run_ok && s_q.pend[SRC_PD] && s_q.isr == '0 |-> s_take(SRC_PD);
  endproperty
  a_pd_nomask: assert property (p_pd_nomask) else $error("power-down not taken");
  property p_mask_block;
    reg_wr && reg_addr == OFS_MASK |=> !svc ##1 !vector_valid;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("service after mask write");
  property p_sequential;
    !s_q.ctrl[CTRL_NEST_BIT] && s_q.isr != '0 |-> !svc;
  endproperty
  a_sequential: assert property (p_sequential) else $error("preempted in sequential");
  property p_gie;
    !s_q.gie |-> !svc;
  endproperty
  a_gie: assert property (p_gie) else $error("serviced while disabled");
  property p_gie_rst;
    $past(sys_rst) |-> s_q.gie && s_q.state == PWR_RUN;
  endproperty
  a_gie_rst: assert property (p_gie_rst) else $error("reset state wrong");
  property p_wake_run;
    s_pd_exit |-> ##299 (s_q.state == PWR_WAKE) ##1 (s_q.state == PWR_RUN);
  endproperty
  a_wake_run: assert property (p_wake_run) else $error("wake time not 300");
  property p_ack;
    s_q.state == PWR_PD |-> power_down_ack && !core_clk_en;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge low in power-down");
  property p_idle_exit;
    s_q.state == PWR_IDLE && svc |=> s_q.state == PWR_RUN && vector_valid;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle did not resume");
  // a service may end slow idle inside the window, after which run rate is legal
  property p_slow16;
    s_q.state == PWR_SLOW && s_q.div == 3'h1 && core_clk_en |=>
      (!core_clk_en || s_q.state == PWR_RUN) [*8];
  endproperty
  a_slow16: assert property (p_slow16) else $error("slow enable too fast");
  property p_edge_clr;
    s_take(SRC_EDGE) && !fall[3] |=> !s_q.pend[SRC_EDGE];
  endproperty
  a_edge_clr: assert property (p_edge_clr) else $error("edge latch not cleared");
endmodule // irq_lp_ctrl

// [hdl/irq_lp_pkg.sv]
// constants, register map and encodings of the interrupt and low-power controller
package irq_lp_pkg;
  localparam int NSRC   = 11;
  localparam int IDX_W  = 4;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 32;
  localparam int VEC_W  = 14;
  localparam int CTRL_W = 6;

  // register word addresses
  localparam logic [ADDR_W-1:0] OFS_MASK        = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL        = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_FORCE_CLEAR = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_PD_FORCE    = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_STATUS      = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_PENDING     = 3'h5;

  // field positions
  localparam int CTRL_EDGE_LSB     = 0;
  localparam int CTRL_NEST_BIT     = 3;
  localparam int CTRL_RESTART_BIT  = 4;
  localparam int CTRL_XTAL_OFF_BIT = 5;
  localparam int FC_CLEAR_LSB      = 16;
  localparam int PD_FORCE_BIT      = 0;
  localparam int STAT_DEPTH_LSB    = 16;
  localparam int STAT_GIE_BIT      = 20;
  localparam int STAT_ACK_BIT      = 21;
  localparam int STAT_STATE_LSB    = 24;

  // reset values
  localparam logic [NSRC-1:0]   MASK_RST = 11'h000;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic              GIE_RST  = 1'b1;

  // sources, in priority order, highest first
  localparam logic [IDX_W-1:0] SRC_PD    = 4'h0;
  localparam logic [IDX_W-1:0] SRC_EXT2  = 4'h1;
  localparam logic [IDX_W-1:0] SRC_LVL1  = 4'h2;
  localparam logic [IDX_W-1:0] SRC_LVL0  = 4'h3;
  localparam logic [IDX_W-1:0] SRC_SA_TX = 4'h4;
  localparam logic [IDX_W-1:0] SRC_SA_RX = 4'h5;
  localparam logic [IDX_W-1:0] SRC_EDGE  = 4'h6;
  localparam logic [IDX_W-1:0] SRC_DMA   = 4'h7;
  localparam logic [IDX_W-1:0] SRC_SB_TX = 4'h8;
  localparam logic [IDX_W-1:0] SRC_SB_RX = 4'h9;
  localparam logic [IDX_W-1:0] SRC_TIMER = 4'hA;

  localparam logic [VEC_W-1:0] VEC_RESET = 14'h0000;
  localparam logic [VEC_W-1:0] VEC_PD    = 14'h002C;
  localparam logic [3:0]       STACK_LEVELS = 4'hC;

  // wake-up times in input clock cycles; input clock feeds sys_clk directly
  localparam longint SYS_HZ        = 50_000_000;
  localparam longint INCLK_HZ      = 50_000_000;
  localparam longint WAKE_RUN_INCLK  = 300;
  localparam longint WAKE_XTAL_INCLK = 4096;
  localparam longint WAKE_RUN_CYC  = (WAKE_RUN_INCLK * SYS_HZ) / INCLK_HZ;
  localparam longint WAKE_XTAL_CYC = (WAKE_XTAL_INCLK * SYS_HZ + INCLK_HZ - 1) / INCLK_HZ;
  localparam logic [11:0] WAKE_RUN_LOAD  = 12'(WAKE_RUN_CYC - 2);
  localparam logic [11:0] WAKE_XTAL_LOAD = 12'(WAKE_XTAL_CYC - 2);

  localparam logic [2:0] IDLE_PLAIN = 3'h0;

  typedef enum logic [2:0] {
    PWR_RUN  = 3'b000,
    PWR_IDLE = 3'b001,
    PWR_SLOW = 3'b010,
    PWR_PD   = 3'b011,
    PWR_WAKE = 3'b100
  } pwr_e;
endpackage
